/* count_source_div.sv */
// count source divider: one-cycle tick every SRC_DIV clocks.
// assumes one clock; the tick is an enable, never a clock.
module count_source_div (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    reload_timer_pkg::div_state_t s_q, s_d;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // free running so the tick phase does not depend on the run flag
    always_comb begin
        s_d = s_q;
        s_d.tick = (s_q.cnt == reload_timer_pkg::SRC_DIV_LAST);
        s_d.cnt = s_d.tick ? 4'h0 : s_q.cnt + 4'h1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;
endmodule

/* reload_timer_mode_control.sv */
// reload timer in plain timer mode, with its Wishbone register slave.
// assumes a classic single-cycle Wishbone master on the system clock;
// byte lane 0 carries every register, upper lanes read as zero.
//
// Added by the designer: the Wishbone register port.
module reload_timer_mode_control (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_request_flag_o
);
    reload_timer_pkg::timer_state_t s_q, s_d;
    logic tick;
    logic req, wr, wr_pre, wr_per, wr_mode, wr_irq;
    logic running, wsel, timer_mode, count_ok;
    logic [7:0] wbyte;

    count_source_div u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a write lands on the edge where ack is high, as the master expects
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && s_q.ack && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign wr_pre = wr && (wb_adr_i == reload_timer_pkg::ADDR_PRESCALER);
    assign wr_per = wr && (wb_adr_i == reload_timer_pkg::ADDR_PERIOD);
    assign wr_mode = wr && (wb_adr_i == reload_timer_pkg::ADDR_MODE_CTRL);
    assign wr_irq = wr && (wb_adr_i == reload_timer_pkg::ADDR_IRQ_CTRL);

    assign running = s_q.mode_ctrl[reload_timer_pkg::RUN_POS];
    assign wsel = s_q.mode_ctrl[reload_timer_pkg::WSEL_POS];
    assign timer_mode = ({s_q.mode_ctrl[reload_timer_pkg::MODE_HI_POS],
                          s_q.mode_ctrl[reload_timer_pkg::MODE_LO_POS]}
                         == reload_timer_pkg::MODE_TIMER);
    // counting pauses while a simultaneous write is being walked in
    assign count_ok = running && timer_mode &&
                      (s_q.phase == reload_timer_pkg::PH_IDLE ||
                       s_q.phase == reload_timer_pkg::PH_RESUME);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // single-cycle answer, ack drops the cycle after
        s_d.ack = req && !s_q.ack;
        s_d.dat = '0;
        case (wb_adr_i)
            reload_timer_pkg::ADDR_MODE_CTRL: s_d.dat[7:0] = s_q.mode_ctrl;
            reload_timer_pkg::ADDR_WAVE_CTRL: s_d.dat[7:0] = s_q.wave_ctrl;
            // reads return the live count, not the reload value
            reload_timer_pkg::ADDR_PRESCALER: s_d.dat[7:0] = s_q.pre_cnt;
            reload_timer_pkg::ADDR_PERIOD: s_d.dat[7:0] = s_q.per_cnt;
            reload_timer_pkg::ADDR_IRQ_CTRL: s_d.dat[reload_timer_pkg::IRQ_POS] = s_q.irq;
            default: s_d.dat = '0;
        endcase

        if (wr_mode) begin
            s_d.mode_ctrl = wbyte;
        end
        if (wr && wb_adr_i == reload_timer_pkg::ADDR_WAVE_CTRL) begin
            s_d.wave_ctrl = wbyte;
        end
        // software clears the flag by writing zero; hardware sets below win
        if (wr_irq && !wbyte[reload_timer_pkg::IRQ_POS]) begin
            s_d.irq = 1'b0;
        end

        // counting and the three-tick write walk
        if (tick) begin
            case (s_q.phase)
                reload_timer_pkg::PH_LOAD: begin
                    if (s_q.pend_pre_v) s_d.pre_rld = s_q.pend_pre;
                    if (s_q.pend_per_v) s_d.per_rld = s_q.pend_per;
                    s_d.phase = reload_timer_pkg::PH_COPY;
                end
                reload_timer_pkg::PH_COPY: begin
                    s_d.pre_cnt = s_q.pre_rld;
                    s_d.per_cnt = s_q.per_rld;
                    s_d.pend_pre_v = 1'b0;
                    s_d.pend_per_v = 1'b0;
                    s_d.phase = reload_timer_pkg::PH_RESUME;
                end
                reload_timer_pkg::PH_RESUME: s_d.phase = reload_timer_pkg::PH_IDLE;
                default: s_d.phase = s_q.phase;
            endcase
            if (count_ok) begin
                if (s_q.pre_cnt != 8'h00) begin
                    s_d.pre_cnt = s_q.pre_cnt - 8'h01;
                end else begin
                    s_d.pre_cnt = s_q.pre_rld;
                    if (s_q.per_cnt != 8'h00) begin
                        s_d.per_cnt = s_q.per_cnt - 8'h01;
                    end else begin
                        s_d.per_cnt = s_q.per_rld;
                        s_d.irq = 1'b1;
                    end
                end
            end
        end

        // a stop abandons any half-walked write
        if (!running) begin
            s_d.phase = reload_timer_pkg::PH_IDLE;
            s_d.pend_pre_v = 1'b0;
            s_d.pend_per_v = 1'b0;
        end

        if (wr_pre || wr_per) begin
            if (!running) begin
                if (wr_pre) begin
                    s_d.pre_rld = wbyte;
                    s_d.pre_cnt = wbyte;
                end
                if (wr_per) begin
                    s_d.per_rld = wbyte;
                    s_d.per_cnt = wbyte;
                end
            end else if (wsel) begin
                if (wr_pre) s_d.pre_rld = wbyte;
                if (wr_per) s_d.per_rld = wbyte;
            end else begin
                if (wr_pre) begin
                    s_d.pend_pre = wbyte;
                    s_d.pend_pre_v = 1'b1;
                end
                if (wr_per) begin
                    s_d.pend_per = wbyte;
                    s_d.pend_per_v = 1'b1;
                end
                s_d.phase = reload_timer_pkg::PH_LOAD;
                s_d.irq = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.mode_ctrl <= reload_timer_pkg::MODE_CTRL_RST;
            s_q.wave_ctrl <= reload_timer_pkg::WAVE_CTRL_RST;
            s_q.pre_rld <= reload_timer_pkg::PRESCALER_RST;
            s_q.per_rld <= reload_timer_pkg::PERIOD_RST;
            s_q.pre_cnt <= reload_timer_pkg::PRESCALER_RST;
            s_q.per_cnt <= reload_timer_pkg::PERIOD_RST;
            s_q.phase <= reload_timer_pkg::PH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign irq_request_flag_o = s_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ack_single;
        @(posedge clk_i) disable iff (!rst_n_i)
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack not one cycle");

    property p_mode_halt;
        @(posedge clk_i) disable iff (!rst_n_i)
        tick && !timer_mode && s_q.phase == reload_timer_pkg::PH_IDLE && !wr
        |=> $stable(s_q.pre_cnt);
    endproperty
    a_mode_halt: assert property (p_mode_halt) else $error("counted outside timer mode");

    property p_both_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_pre && running && !wsel |=> s_q.phase == reload_timer_pkg::PH_LOAD
        && s_q.pend_pre == $past(wbyte);
    endproperty
    a_both_start: assert property (p_both_start) else $error("write walk not started");

    property p_reload_only;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_per && running && wsel && s_q.phase == reload_timer_pkg::PH_IDLE
        |=> s_q.per_rld == $past(wbyte) && s_q.phase == reload_timer_pkg::PH_IDLE;
    endproperty
    a_reload_only: assert property (p_reload_only) else $error("reload-only write wrong");

    property p_halted;
        @(posedge clk_i) disable iff (!rst_n_i)
        !running && !wr |=> $stable(s_q.pre_cnt) && $stable(s_q.per_cnt);
    endproperty
    a_halted: assert property (p_halted) else $error("count moved while halted");

    property p_stopped_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_pre && !running |=> s_q.pre_cnt == $past(wbyte) && s_q.pre_rld == $past(wbyte);
    endproperty
    a_stopped_load: assert property (p_stopped_load) else $error("stopped write missed");

    sequence s_load_tick;
        s_q.phase == reload_timer_pkg::PH_LOAD && tick && running && !wr;
    endsequence
    property p_walk;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_load_tick |=> s_q.phase == reload_timer_pkg::PH_COPY;
    endproperty
    a_walk: assert property (p_walk) else $error("reload tick skipped");

    property p_copy;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_q.phase == reload_timer_pkg::PH_COPY && tick && running && !wr
        |=> s_q.pre_cnt == $past(s_q.pre_rld) && s_q.phase == reload_timer_pkg::PH_RESUME;
    endproperty
    a_copy: assert property (p_copy) else $error("counter copy wrong");

    property p_irq_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_pre || wr_per) && running && !wsel |=> irq_request_flag_o;
    endproperty
    a_irq_write: assert property (p_irq_write) else $error("request not raised");
endmodule

/* reload_timer_mode_control_tb.sv */
// testbench for the reload timer mode control block and its register slave.
// assumes the block answers a classic Wishbone cycle and ticks every two clocks.
module reload_timer_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_request_flag_o;
    int n_fail = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [31:0] rd2;

    // 100 MHz system clock
    always #5 clk_i = ~clk_i;

    reload_timer_mode_control dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_request_flag_o(irq_request_flag_o)
    );

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    // one classic cycle; request held until ack is sampled, bounded wait
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                            input logic [3:0] sel, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] q;
        wb_cycle(1'b1, adr, {24'h0, dat}, 4'h1, q);
    endtask

    task automatic rd_reg(input logic [7:0] adr, output logic [31:0] q);
        wb_cycle(1'b0, adr, 32'h0, 4'h1, q);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    initial begin
        #50000;
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        idle(10);
        rst_n_i <= 1'b1;
        // reset values, plus an unmapped address that reads zero
        rd_reg(reload_timer_pkg::ADDR_MODE_CTRL, rd);
        check(rd, 32'h00);
        rd_reg(reload_timer_pkg::ADDR_WAVE_CTRL, rd);
        check(rd, 32'h00);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check(rd, 32'hff);
        rd_reg(reload_timer_pkg::ADDR_PERIOD, rd);
        check(rd, 32'hff);
        rd_reg(reload_timer_pkg::ADDR_IRQ_CTRL, rd);
        check(rd, 32'h00);
        wr(8'ha0, 8'hff);
        rd_reg(8'ha0, rd);
        check(rd, 32'h00);
        wr(reload_timer_pkg::ADDR_WAVE_CTRL, 8'h5a);
        // a write without byte lane 0 selected must leave the register alone
        wb_cycle(1'b1, reload_timer_pkg::ADDR_WAVE_CTRL, 32'h000000a5, 4'h0, rd);
        rd_reg(reload_timer_pkg::ADDR_WAVE_CTRL, rd);
        check(rd, 32'h5a);
        $display("test registers done");
        // halted with select one still loads the counter
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'h7f);
        rd_reg(reload_timer_pkg::ADDR_MODE_CTRL, rd);
        check(rd, 32'h7f);
        wr(reload_timer_pkg::ADDR_PRESCALER, 8'h40);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check(rd, 32'h40);
        // run flag set but mode 10 is not timer mode, so no counting
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'ha0);
        idle(20);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check(rd, 32'h40);
        $display("test halted load done");
        // running with select one: reload only, no request raised
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'h00);
        wr(reload_timer_pkg::ADDR_PRESCALER, 8'h7f);
        wr(reload_timer_pkg::ADDR_PERIOD, 8'hf0);
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'hc0);
        idle(20);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check({31'h0, rd < 32'h7f}, 32'h1);
        wr(reload_timer_pkg::ADDR_PERIOD, 8'h05);
        rd_reg(reload_timer_pkg::ADDR_PERIOD, rd);
        check(rd, 32'hf0);
        rd_reg(reload_timer_pkg::ADDR_IRQ_CTRL, rd);
        check(rd, 32'h00);
        // stop: the count freezes and a write reaches the counter again
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'h40);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        idle(20);
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd2);
        check(rd2, rd);
        wr(reload_timer_pkg::ADDR_PERIOD, 8'h22);
        rd_reg(reload_timer_pkg::ADDR_PERIOD, rd);
        check(rd, 32'h22);
        $display("test reload only done");
        // running with select zero: request raised, counter reloaded after two ticks
        wr(reload_timer_pkg::ADDR_PRESCALER, 8'h70);
        wr(reload_timer_pkg::ADDR_MODE_CTRL, 8'h80);
        wr(reload_timer_pkg::ADDR_PRESCALER, 8'h40);
        // straight after the write the counter still holds the old count
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check({31'h0, rd > 32'h40 && rd <= 32'h70}, 32'h1);
        rd_reg(reload_timer_pkg::ADDR_IRQ_CTRL, rd);
        check(rd, 32'h01);
        check({31'h0, irq_request_flag_o}, 32'h1);
        idle(20);
        // about thirteen ticks have passed; two went to the load and copy
        rd_reg(reload_timer_pkg::ADDR_PRESCALER, rd);
        check({31'h0, rd >= 32'h30 && rd <= 32'h3e}, 32'h1);
        check({31'h0, rd <= 32'h40}, 32'h1);
        wr(reload_timer_pkg::ADDR_IRQ_CTRL, 8'h00);
        rd_reg(reload_timer_pkg::ADDR_IRQ_CTRL, rd);
        check(rd, 32'h00);
        check({31'h0, irq_request_flag_o}, 32'h0);
        $display("test simultaneous write done");
        results();
    end
endmodule

/* reload_timer_pkg.sv */
// reload timer package: register map, field positions, reset values,
// timing constants, the timer mode value, the write-phase type, state carriers.
// assumes a 100 MHz system clock and a 32-bit classic Wishbone master.
package reload_timer_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h80;
    localparam logic [7:0] ADDR_WAVE_CTRL = 8'h84;
    localparam logic [7:0] ADDR_PRESCALER = 8'h88;
    localparam logic [7:0] ADDR_PERIOD = 8'h8c;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h90;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_HI_POS = 5;
    localparam int MODE_LO_POS = 4;
    localparam int RUN_POS = 7;
    localparam int WSEL_POS = 6;
    localparam int IRQ_POS = 0;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] WAVE_CTRL_RST = 8'h00;
    localparam logic [7:0] PRESCALER_RST = 8'hff;
    localparam logic [7:0] PERIOD_RST = 8'hff;

    // ------------------------------------------------------------
    // timing: count source period and its cycle count
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SRC_PERIOD_NS = 20;
    localparam int SRC_DIV = (SRC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SRC_DIV_LAST = 4'(SRC_DIV - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_COPY, PH_RESUME} wr_phase_t;

    typedef struct packed {
        logic [7:0] mode_ctrl;
        logic [7:0] wave_ctrl;
        logic [7:0] pre_rld;
        logic [7:0] per_rld;
        logic [7:0] pre_cnt;
        logic [7:0] per_cnt;
        logic [7:0] pend_pre;
        logic [7:0] pend_per;
        logic pend_pre_v;
        logic pend_per_v;
        wr_phase_t phase;
        logic irq;
        logic ack;
        logic [31:0] dat;
    } timer_state_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } div_state_t;
endpackage
